// ===== logic/device_ctrl_regs.sv
// Device end: address decode and device-wide control, status and action registers.
//
// Overview of operation
// - Decode channels, device window; gaps undefined.
// - Host waits four clocks before same-address reaccess.
// - Different addresses may follow back to back.
// - Master loads on write, slave on clock.
// - Masters host-writable, cleared by hard reset.
// - Readable slaves cleared by hard/soft reset.
// - Indirect pages of 256, bits 9:8 select.
// - Indirect bit 15: one reads, zero writes.
// - Self-test valid clears on test toggle.
// - Self-test signature 14:3, revision 2:0.
// - Channel fault is OR of faults.
// - Status 9:0 saturation flags, bit 11 summary.
// - Saturation clamps to max or min+1.
// - Writing one to 15:11 clears faults.
// - Channel fault clear clears channel status.
// - Output fault clear clears bits 9:0.
// - Action bit 1 gives hard reset pulse.
// - Action bit 0 gives sync pulse.
// - Routing via update strobe; control direct.
// - Host writes zero to reserved bits.
`timescale 1ns/1ns
`default_nettype none
module device_ctrl_regs
  import upconv_map_pkg::*;
#(
  parameter int unsigned                    SAT_W    = 20,
  parameter logic [upconv_map_pkg::REV_MSB:0] REVISION = 3'h5 // Arbitrary value.
) (
  input  wire logic                         ref_clk,
  input  wire logic                         nrst,
  host_port_if.device                       hp,
  input  wire logic                         soft_reset,
  input  wire logic                         update_strobe,
  input  wire logic [3:0][DATA_W-1:0]       ch_status,
  output logic      [3:0]                   ch_status_clear,
  input  wire logic [SAT_MSB:0]             sat_events,
  input  wire logic                         selftest_done,
  input  wire logic [ST_SIG_MSB-ST_SIG_LSB:0] selftest_sig,
  input  wire logic [SAT_W-1:0]             clamp_in,
  input  wire logic                         clamp_ovf,
  output logic      [SAT_W-1:0]             clamp_out,
  output logic      [DATA_W-1:0]            device_control,
  output logic      [DATA_W-1:0]            output_routing,
  output logic                              hard_reset_pulse,
  output logic                              sync_pulse,
  output logic      [2:0]                   ch_sel,
  output logic                              ch_access,
  output logic      [ADDR_W-1:0]            ch_addr,
  output logic                              ind_read,
  output logic      [1:0]                   ind_page,
  output logic                              ind_page_valid
);
  import upconv_map_pkg::*;

  // ----------------------------------------------------------------
  // Decode and clamp helpers
  // ----------------------------------------------------------------
  function automatic window_t decode(input logic [ADDR_W-1:0] a);
    if (a >= DEV_WIN_BASE) begin
      decode = WIN_DEV;
    end else if (a[4:0] > CH_WIN_LAST[4:0]) begin
      decode = WIN_NONE;
    end else begin
      decode = window_t'({1'b0, a[6:5]});
    end
  endfunction : decode

  // Clamp a wrapped sum: most positive or most negative plus one.
  function automatic logic [SAT_W-1:0] clamp(input logic [SAT_W-1:0] v, input logic ovf);
    if (!ovf) begin
      clamp = v;
    end else if (v[SAT_W-1]) begin
      clamp = {1'b0, {(SAT_W-1){1'b1}}};
    end else begin
      clamp = {1'b1, {(SAT_W-2){1'b0}}, 1'b1};
    end
  endfunction : clamp

  // ----------------------------------------------------------------
  // Host port synchronisers
  // ----------------------------------------------------------------
  logic [ADDR_W-1:0] addr_s1_reg, addr_reg;
  logic [DATA_W-1:0] data_s1_reg, data_reg;
  logic [2:0]        strb_s1_reg, strb_reg;  // {cs_n, wr_n, rd_n}.
  logic              wr_d_reg;

  // Two flops on every pin before use.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      addr_s1_reg <= '0;
      addr_reg    <= '0;
      data_s1_reg <= '0;
      data_reg    <= '0;
      strb_s1_reg <= 3'h7;
      strb_reg    <= 3'h7;
      wr_d_reg    <= 1'b0;
    end else begin
      addr_s1_reg <= hp.addr;
      addr_reg    <= addr_s1_reg;
      data_s1_reg <= hp.bus_level;
      data_reg    <= data_s1_reg;
      strb_s1_reg <= {hp.cs_n, hp.wr_n, hp.rd_n};
      strb_reg    <= strb_s1_reg;
      wr_d_reg    <= !strb_reg[2] && !strb_reg[1];
    end
  end

  logic    wr_active;
  logic    wr_pulse;  // Rising edge of a selected write: data stable by now.
  logic    rd_active;
  window_t win;
  assign wr_active = !strb_reg[2] && !strb_reg[1];
  assign wr_pulse  = wr_active && !wr_d_reg;
  assign rd_active = !strb_reg[2] && !strb_reg[0];
  assign win       = decode(addr_reg);

  // Channel window outputs for the per-channel blocks; indirect fields pass on.
  assign ch_sel         = win;
  assign ch_access      = (win != WIN_DEV) && (win != WIN_NONE) && (wr_active || rd_active);
  assign ch_addr        = addr_reg;
  assign ind_read       = data_reg[IND_RW_BIT];
  assign ind_page       = data_reg[IND_PAGE_MSB:IND_PAGE_LSB];
  assign ind_page_valid = ind_page < IND_PAGES;

  // ----------------------------------------------------------------
  // Master and slave configuration registers
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] ctrl_master_reg, route_master_reg, route_slave_reg, ctrl_slave_reg;
  logic              hard_rst_reg;
  logic              dev_wr;
  assign dev_wr = wr_pulse && (win == WIN_DEV);

  // Masters load on the write strobe and clear only on hard reset.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_master_reg  <= DEVICE_CONTROL_RESET;
      route_master_reg <= OUTPUT_ROUTING_RESET;
    end else if (hard_rst_reg) begin
      ctrl_master_reg  <= DEVICE_CONTROL_RESET;
      route_master_reg <= OUTPUT_ROUTING_RESET;
    end else if (dev_wr && addr_reg == DEVICE_CONTROL_ADDR) begin
      ctrl_master_reg <= data_reg;
    end else if (dev_wr && addr_reg == OUTPUT_ROUTING_ADDR) begin
      route_master_reg <= data_reg;
    end
  end

  // Slaves follow on the clock: control at once, routing on the update strobe.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_slave_reg  <= DEVICE_CONTROL_RESET;
      route_slave_reg <= OUTPUT_ROUTING_RESET;
    end else if (hard_rst_reg || soft_reset) begin
      ctrl_slave_reg  <= DEVICE_CONTROL_RESET;
      route_slave_reg <= OUTPUT_ROUTING_RESET;
    end else begin
      ctrl_slave_reg <= ctrl_master_reg;
      if (update_strobe) begin
        route_slave_reg <= route_master_reg;
      end
    end
  end
  assign device_control = ctrl_slave_reg;
  assign output_routing = route_slave_reg;

  // ----------------------------------------------------------------
  // Immediate action pulses
  // ----------------------------------------------------------------
  logic sync_reg;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      hard_rst_reg <= 1'b0;
      sync_reg     <= 1'b0;
    end else begin
      hard_rst_reg <= dev_wr && addr_reg == IMMEDIATE_ACTION_ADDR && data_reg[ACT_HARD_RST];
      sync_reg     <= dev_wr && addr_reg == IMMEDIATE_ACTION_ADDR && data_reg[ACT_SYNC];
    end
  end
  assign hard_reset_pulse = hard_rst_reg;
  assign sync_pulse       = sync_reg;

  // ----------------------------------------------------------------
  // Self-test register
  // ----------------------------------------------------------------
  logic                            st_valid_reg, test_d_reg;
  logic [ST_SIG_MSB-ST_SIG_LSB:0] st_sig_reg;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      st_valid_reg <= 1'b0;
      st_sig_reg   <= '0;
      test_d_reg   <= 1'b0;
    end else begin
      test_d_reg <= ctrl_slave_reg[TEST_MODE_BIT];
      if (test_d_reg != ctrl_slave_reg[TEST_MODE_BIT]) begin
        st_valid_reg <= 1'b0;
      end else if (selftest_done) begin
        st_valid_reg <= 1'b1;
        st_sig_reg   <= selftest_sig;
      end
    end
  end

  // ----------------------------------------------------------------
  // Fault status: set wins over write-one-to-clear
  // ----------------------------------------------------------------
  logic [SAT_MSB:0] sat_reg;
  logic             fault_wr;
  logic [3:0]       ch_fault;
  assign fault_wr = dev_wr && addr_reg == FAULT_STATUS_ADDR;
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      ch_fault[i] = |(ch_status[i] & CH_FAULT_MASK);
    end
  end
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      sat_reg <= '0;
    end else if (hard_rst_reg) begin
      sat_reg <= '0;
    end else if (fault_wr && data_reg[FLT_OUT_BIT]) begin
      sat_reg <= sat_events;
    end else begin
      sat_reg <= sat_reg | sat_events;
    end
  end
  assign ch_status_clear = fault_wr ? data_reg[FLT_CH_LSB+:4] : 4'h0;
  assign clamp_out       = clamp(clamp_in, clamp_ovf);

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] rd_data_reg;
  logic              rd_oe_reg;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rd_data_reg <= '0;
      rd_oe_reg   <= 1'b0;
    end else begin
      rd_oe_reg <= rd_active && (win == WIN_DEV);
      case (addr_reg)
        DEVICE_CONTROL_ADDR: rd_data_reg <= ctrl_slave_reg;
        OUTPUT_ROUTING_ADDR: rd_data_reg <= route_slave_reg;
        SELFTEST_REV_ADDR:   rd_data_reg <= {st_valid_reg, st_sig_reg, REVISION};
        FAULT_STATUS_ADDR:   rd_data_reg <= {ch_fault, |sat_reg, 1'b0, sat_reg};
        default:             rd_data_reg <= '0;
      endcase
    end
  end
  assign hp.dev_data = rd_data_reg;
  assign hp.dev_oe   = rd_oe_reg;

endmodule : device_ctrl_regs
`default_nettype wire

// ===== logic/upconv_map_pkg.sv
// Package with address map, field positions and timing counts of the device-control block.
package upconv_map_pkg;

  // ----------------------------------------------------------------
  // Bus widths and address map
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 7;
  localparam int unsigned DATA_W = 16;

  localparam logic [6:0] CH_WIN_LAST  = 7'h17; // Last word of each channel window.
  localparam logic [6:0] DEV_WIN_BASE = 7'h78;

  localparam logic [6:0] DEVICE_CONTROL_ADDR   = 7'h78;
  localparam logic [6:0] OUTPUT_ROUTING_ADDR   = 7'h79;
  localparam logic [6:0] SELFTEST_REV_ADDR     = 7'h7D;
  localparam logic [6:0] FAULT_STATUS_ADDR     = 7'h7E;
  localparam logic [6:0] IMMEDIATE_ACTION_ADDR = 7'h7F;

  localparam logic [15:0] DEVICE_CONTROL_RESET = 16'h0000;
  localparam logic [15:0] OUTPUT_ROUTING_RESET = 16'h0000;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned TEST_MODE_BIT   = 14;
  localparam int unsigned ST_VALID_BIT    = 15;
  localparam int unsigned ST_SIG_MSB      = 14;
  localparam int unsigned ST_SIG_LSB      = 3;
  localparam int unsigned REV_MSB         = 2;
  localparam int unsigned FLT_CH_LSB      = 12;
  localparam int unsigned FLT_OUT_BIT     = 11;
  localparam int unsigned SAT_MSB         = 9;
  localparam int unsigned ACT_HARD_RST    = 1;
  localparam int unsigned ACT_SYNC        = 0;
  localparam logic [15:0] CH_FAULT_MASK   = 16'h0788; // Channel status bits 10:7 and 3.

  // Indirect address fields.
  localparam int unsigned IND_RW_BIT   = 15;
  localparam int unsigned IND_PAGE_MSB = 9;
  localparam int unsigned IND_PAGE_LSB = 8;
  localparam logic [1:0]  IND_PAGES    = 2'd3;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned UPDATE_CLKS = 4; // Synchronized update length in clocks.

  // Address window that an access falls in.
  typedef enum logic [2:0] {WIN_CH0, WIN_CH1, WIN_CH2, WIN_CH3, WIN_DEV, WIN_NONE} window_t;

endpackage : upconv_map_pkg

// ===== logic/host_port_if.sv
// Interface carrying the 16-bit parallel host port between host and device.
`timescale 1ns/1ns
`default_nettype none
interface host_port_if;
  import upconv_map_pkg::*;
  logic [ADDR_W-1:0] addr;
  logic              cs_n;
  logic              wr_n;
  logic              rd_n;
  logic [DATA_W-1:0] host_data;  // Host drive of P.
  logic              host_oe;
  logic [DATA_W-1:0] dev_data;   // Device drive of P.
  logic              dev_oe;
  logic [DATA_W-1:0] bus_level;  // Resolved level of P.

  assign bus_level = dev_oe ? dev_data : (host_oe ? host_data : '0);

  modport device (input addr, cs_n, wr_n, rd_n, bus_level, output dev_data, dev_oe);
  modport host (output addr, cs_n, wr_n, rd_n, host_data, host_oe, input bus_level);
endinterface : host_port_if
`default_nettype wire

// ===== logic/host_port_master.sv
// Host end: drives the parallel port for single reads and writes.
`timescale 1ns/1ns
`default_nettype none
module host_port_master
  import upconv_map_pkg::*;
#(
  parameter int unsigned STROBE_CLKS = 4
) (
  input  wire logic                       ref_clk,
  input  wire logic                       nrst,
  host_port_if.host                       hp,
  input  wire logic                       req_valid,
  input  wire logic                       req_write,
  input  wire logic [upconv_map_pkg::ADDR_W-1:0] req_addr,
  input  wire logic [upconv_map_pkg::DATA_W-1:0] req_wdata,
  output logic                            req_ready,
  output logic                            rsp_valid,
  output logic      [upconv_map_pkg::DATA_W-1:0] rsp_rdata
);
  import upconv_map_pkg::*;

  typedef enum logic [1:0] {IDLE, STROBE, GAP} state_t;
  state_t            state_reg;
  logic [3:0]        cnt_reg;
  logic              write_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic [DATA_W-1:0] wdata_reg, rdata_reg, s1_reg, s2_reg;
  logic              rsp_reg;

  // ----------------------------------------------------------------
  // Access sequencer
  // ----------------------------------------------------------------
  // Strobe held long enough for the device synchronisers; then a gap covering
  // the synchronized update, which makes same-address reaccess safe.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= IDLE;
      cnt_reg   <= '0;
      write_reg <= 1'b0;
      addr_reg  <= '0;
      wdata_reg <= '0;
      rsp_reg   <= 1'b0;
    end else begin
      rsp_reg <= 1'b0;
      case (state_reg)
        IDLE: begin
          if (req_valid) begin
            state_reg <= STROBE;
            write_reg <= req_write;
            addr_reg  <= req_addr;
            wdata_reg <= req_wdata; // Caller keeps reserved bits zero.
            cnt_reg   <= 4'(STROBE_CLKS);
          end
        end
        STROBE: begin
          cnt_reg <= cnt_reg - 4'h1;
          if (cnt_reg == 4'h1) begin
            state_reg <= GAP;
            cnt_reg   <= 4'(UPDATE_CLKS);
          end
        end
        // The answer is raised with the read capture, once read data has
        // crossed both the device pipeline and our own two flops.
        GAP: begin
          cnt_reg <= cnt_reg - 4'h1;
          if (cnt_reg == 4'(UPDATE_CLKS - 1)) begin
            rsp_reg <= 1'b1;
          end
          if (cnt_reg == 4'h1) begin
            state_reg <= IDLE;
          end
        end
        default: state_reg <= IDLE;
      endcase
    end
  end

  // Read data passes two flops from the pins before capture. The device
  // answers three clocks into the strobe and keeps driving into the gap, so
  // the capture waits until the second gap clock, when both flops hold it.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      s1_reg    <= '0;
      s2_reg    <= '0;
      rdata_reg <= '0;
    end else begin
      s1_reg <= hp.bus_level;
      s2_reg <= s1_reg;
      if (state_reg == GAP && cnt_reg == 4'(UPDATE_CLKS - 1)) begin
        rdata_reg <= write_reg ? '0 : s2_reg;
      end
    end
  end

  assign hp.addr      = addr_reg;
  assign hp.cs_n      = !(state_reg == STROBE);
  assign hp.wr_n      = !(state_reg == STROBE && write_reg);
  assign hp.rd_n      = !(state_reg == STROBE && !write_reg);
  assign hp.host_data = wdata_reg;
  assign hp.host_oe   = state_reg == STROBE && write_reg;
  assign req_ready    = state_reg == IDLE;
  assign rsp_valid    = rsp_reg;
  assign rsp_rdata    = rdata_reg;

endmodule : host_port_master
`default_nettype wire

// ===== bench/host_port_chk.sv
// Concurrent checks on the host port between the host end and the device end.
`timescale 1ns/1ns
`default_nettype none
module host_port_chk
  import upconv_map_pkg::*;
(
  input wire logic                              ref_clk,
  input wire logic                              nrst,
  input wire logic [upconv_map_pkg::ADDR_W-1:0] addr,
  input wire logic                              cs_n,
  input wire logic                              wr_n,
  input wire logic                              rd_n,
  input wire logic                              host_oe,
  input wire logic [upconv_map_pkg::DATA_W-1:0] dev_data,
  input wire logic                              dev_oe
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  // Gap addresses and the places that cannot be read back.
  logic dead;
  assign dead = (addr[4:3] == 2'b11 && addr[6:5] != 2'b11) ||
                (addr inside {7'h7A, 7'h7B, 7'h7C, 7'h7F});

  // An access holds its strobe for four clocks, then idles for four.
  sequence s_strobe;
    (!cs_n) [*4];
  endsequence
  sequence s_gap;
    cs_n [*4];
  endsequence

  a_strobe_length: assert property ($fell(cs_n) |-> s_strobe)
    else $error("strobe shorter than four clocks");
  a_gap_after_access: assert property ($rose(cs_n) |-> s_gap)
    else $error("new access before the update finished");
  a_addr_held: assert property (!cs_n && !$past(cs_n) |-> $stable(addr) && $stable(wr_n))
    else $error("address or direction moved within an access");
  a_write_drives: assert property (!cs_n && !wr_n |-> host_oe)
    else $error("write without host data on the bus");
  a_one_direction: assert property (!cs_n |-> wr_n != rd_n)
    else $error("access is neither a single read nor a single write");
  a_no_contention: assert property (dev_oe |-> !host_oe)
    else $error("both ends drive the data bus");
  a_read_answer: assert property ($rose(dev_oe) |-> !$past(cs_n, 3) && !$past(rd_n, 3))
    else $error("device drove the bus without a read three clocks before");
  a_dead_read_zero: assert property (dev_oe && $past(dead, 3) |-> dev_data == 16'h0000)
    else $error("unreadable address returned nonzero data");
endmodule : host_port_chk
`default_nettype wire

// ===== bench/device_map_and_control_regs_tb_top.sv
// Testbench joining host end and device end over the host port interface.
`timescale 1ns/1ns
`default_nettype none
module device_map_and_control_regs_tb_top;
  import upconv_map_pkg::*;
  logic ref_clk = 1'b0, nrst = 1'b0, req_valid = 1'b0, req_write = 1'b0;
  logic [6:0] req_addr = '0;
  logic [15:0] req_wdata = '0, rsp_rdata, device_control, output_routing;
  logic req_ready, rsp_valid, hard_reset_pulse, sync_pulse, ch_access;
  logic soft_reset = 1'b0, update_strobe = 1'b0, selftest_done = 1'b0, clamp_ovf = 1'b0;
  logic [3:0][15:0] ch_status = '0;
  logic [3:0] ch_status_clear, clr_seen = '0, seen_ind = '0;
  logic [9:0] sat_events = '0;
  logic [11:0] selftest_sig = 12'hABC;
  logic [19:0] clamp_in = '0, clamp_out;
  logic [2:0] ch_sel, last_sel;
  logic [6:0] ch_addr, seen_addr = '0;
  logic ind_read, ind_page_valid;
  logic [1:0] ind_page;
  int n_mismatch = 0, check_count = 0, n_sync = 0, n_hard = 0;
  logic [6:0] dec_addr [12] = '{7'h00, 7'h17, 7'h18, 7'h20, 7'h37, 7'h3F,
                                7'h40, 7'h57, 7'h60, 7'h77, 7'h78, 7'h7F};
  logic [2:0] dec_sel [12] = '{3'd0, 3'd0, 3'd5, 3'd1, 3'd1, 3'd5,
                               3'd2, 3'd2, 3'd3, 3'd3, 3'd4, 3'd4};

  always #10 ref_clk = ~ref_clk;

  host_port_if hp_bus ();
  // The revision value is arbitrary.
  device_ctrl_regs #(.REVISION(3'h6)) u_device_ctrl_regs (
    .ref_clk(ref_clk), .nrst(nrst), .hp(hp_bus), .soft_reset(soft_reset),
    .update_strobe(update_strobe), .ch_status(ch_status), .ch_status_clear(ch_status_clear),
    .sat_events(sat_events), .selftest_done(selftest_done), .selftest_sig(selftest_sig),
    .clamp_in(clamp_in), .clamp_ovf(clamp_ovf), .clamp_out(clamp_out),
    .device_control(device_control), .output_routing(output_routing),
    .hard_reset_pulse(hard_reset_pulse), .sync_pulse(sync_pulse), .ch_sel(ch_sel),
    .ch_access(ch_access), .ch_addr(ch_addr), .ind_read(ind_read), .ind_page(ind_page),
    .ind_page_valid(ind_page_valid));
  host_port_master u_host_port_master (
    .ref_clk(ref_clk), .nrst(nrst), .hp(hp_bus), .req_valid(req_valid),
    .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata));
  host_port_chk u_host_port_chk (
    .ref_clk(ref_clk), .nrst(nrst), .addr(hp_bus.addr), .cs_n(hp_bus.cs_n),
    .wr_n(hp_bus.wr_n), .rd_n(hp_bus.rd_n), .host_oe(hp_bus.host_oe),
    .dev_data(hp_bus.dev_data), .dev_oe(hp_bus.dev_oe));

  // Pulses last one clock, so they are counted on every edge. Channel-side
  // fields only mean something while an access is seen, so they are caught then.
  always @(posedge ref_clk) begin
    n_sync += (sync_pulse === 1'b1);
    n_hard += (hard_reset_pulse === 1'b1);
    if (nrst) begin
      clr_seen |= ch_status_clear;
    end
    if (ch_access === 1'b1) begin
      seen_ind  <= {ind_read, ind_page_valid, ind_page};
      seen_addr <= ch_addr;
    end
  end

  task automatic tick();
    @(posedge ref_clk);
    #1;
  endtask : tick

  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : stop_test

  task automatic chk(input string what, input logic [19:0] exp, input logic [19:0] got);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // One host access; the request is held until the edge that takes it.
  task automatic access(input logic wr, input logic [6:0] a, input logic [15:0] d);
    int n;
    n = 0;
    while (req_ready !== 1'b1 && n < 100) begin
      tick();
      n++;
    end
    req_write = wr;
    req_addr = a;
    req_wdata = d;
    req_valid = 1'b1;
    tick();
    req_valid = 1'b0;
    while (rsp_valid !== 1'b1 && n < 100) begin
      tick();
      n++;
    end
    if (n >= 100) begin
      n_mismatch++;
      $display("unexpected handshake: expected response seen none");
    end
    last_sel = ch_sel;
  endtask : access

  task automatic rd_chk(input string what, input logic [6:0] a, input logic [15:0] exp);
    access(1'b0, a, 16'h0000);
    chk(what, {4'h0, exp}, {4'h0, rsp_rdata});
  endtask : rd_chk

  task automatic pulse_update();
    update_strobe = 1'b1;
    tick();
    update_strobe = 1'b0;
    tick();
  endtask : pulse_update

  // Main sequence of register scenarios.
  initial begin
    repeat (12) @(posedge ref_clk);
    #1;
    nrst = 1'b1;
    tick();
    rd_chk("control", 7'h78, 16'h0000);
    rd_chk("routing", 7'h79, 16'h0000);
    rd_chk("action", 7'h7F, 16'h0000);
    rd_chk("unused", 7'h7B, 16'h0000);
    access(1'b1, 7'h78, 16'h00A5);
    access(1'b1, 7'h79, 16'h1234);
    chk("control out", 20'h000A5, {4'h0, device_control});
    chk("routing held", 20'h0, {4'h0, output_routing});
    pulse_update();
    chk("routing out", 20'h01234, {4'h0, output_routing});
    rd_chk("routing", 7'h79, 16'h1234);
    soft_reset = 1'b1;
    tick();
    tick();
    chk("routing soft", 20'h0, {4'h0, output_routing});
    soft_reset = 1'b0;
    pulse_update();
    chk("routing master", 20'h01234, {4'h0, output_routing});
    access(1'b1, 7'h78, 16'h4000);
    rd_chk("selftest", 7'h7D, 16'h0006);
    selftest_done = 1'b1;
    tick();
    selftest_done = 1'b0;
    rd_chk("selftest done", 7'h7D, 16'hD5E6);
    access(1'b1, 7'h78, 16'h0000);
    rd_chk("selftest off", 7'h7D, 16'h55E6);
    ch_status[2] = 16'h0080;
    ch_status[0] = 16'h0004;
    sat_events = 10'h010;
    tick();
    sat_events = 10'h000;
    rd_chk("status", 7'h7E, 16'h4810);
    access(1'b1, 7'h7E, 16'h4000);
    chk("channel clear", 20'h4, {16'h0, clr_seen});
    ch_status[2] = 16'h0000;
    rd_chk("status", 7'h7E, 16'h0810);
    access(1'b1, 7'h7E, 16'h0800);
    rd_chk("status", 7'h7E, 16'h0000);
    access(1'b1, 7'h25, 16'h8200);
    chk("channel address", 20'h00025, {13'h0, seen_addr});
    chk("indirect fields", 20'h0000E, {16'h0, seen_ind});
    access(1'b1, 7'h45, 16'h0300);
    chk("indirect page", 20'h00003, {16'h0, seen_ind});
    access(1'b1, 7'h7F, 16'h0001);
    chk("sync", 20'h1, 20'(n_sync));
    chk("hard idle", 20'h0, 20'(n_hard));
    access(1'b1, 7'h7F, 16'h0002);
    chk("hard", 20'h1, 20'(n_hard));
    pulse_update();
    chk("routing hard", 20'h0, {4'h0, output_routing});
    rd_chk("control hard", 7'h78, 16'h0000);
    for (int i = 0; i < 12; i++) begin
      access(1'b0, dec_addr[i], 16'h0000);
      chk("window", {17'h0, dec_sel[i]}, {17'h0, last_sel});
    end
    clamp_in = 20'h12345;
    tick();
    chk("clamp pass", 20'h12345, clamp_out);
    clamp_ovf = 1'b1;
    tick();
    chk("clamp low", 20'h80001, clamp_out);
    clamp_in = 20'h80123;
    tick();
    chk("clamp high", 20'h7FFFF, clamp_out);
    stop_test();
  end

  // Watchdog well beyond the expected run length.
  initial begin
    #400000;
    n_mismatch++;
    $display("unexpected run length: expected end seen watchdog");
    stop_test();
  end
endmodule : device_map_and_control_regs_tb_top
`default_nettype wire
